// *** tcaux_pkg.sv ***
// Constants and types shared by the test control and auxiliary select block.
package tcaux_pkg;
  localparam logic [5:0] ADDR_CTRL      = 6'h36;
  localparam logic [5:0] ADDR_REV       = 6'h37;
  localparam logic [5:0] ADDR_AUX       = 6'h38;
  localparam logic [7:0] CTRL_RESET     = 8'h40;
  localparam logic [7:0] CTRL_WMASK     = 8'h5F;
  localparam logic [7:0] AUX_RESET      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  localparam int         BIT_NL         = 6;
  localparam int         BIT_TRIM       = 4;
  localparam int         ST_HI          = 3;
  localparam int         ST_LO          = 0;
  localparam int         AUXILIARY_PIN_1_HI        = 7;
  localparam int         AUXILIARY_PIN_1_LO        = 4;
  localparam int         AUXILIARY_PIN_2_HI        = 3;
  localparam int         AUXILIARY_PIN_2_LO        = 0;
  localparam logic [3:0] SELF_TEST_ON   = 4'h9;
  localparam logic [3:0] TRIM_CYCLES    = 4'h8;
  localparam logic [3:0] TRIM_NONE      = 4'h0;
  // Auxiliary pin selector codes.
  localparam logic [3:0] SEL_HIZ        = 4'h0;
  localparam logic [3:0] SEL_DAC        = 4'h1;
  localparam logic [3:0] SEL_CORR       = 4'h2;
  localparam logic [3:0] SEL_RSV3       = 4'h3;
  localparam logic [3:0] SEL_MINLVL     = 4'h4;
  localparam logic [3:0] SEL_ADC_I      = 4'h5;
  localparam logic [3:0] SEL_ADC_Q      = 4'h6;
  localparam logic [3:0] SEL_RSV7       = 4'h7;
  localparam logic [3:0] SEL_PROD       = 4'h8;
  localparam logic [3:0] SEL_RSV9       = 4'h9;
  localparam logic [3:0] SEL_HIGH       = 4'hA;
  localparam logic [3:0] SEL_LOW        = 4'hB;
  localparam logic [3:0] SEL_TX         = 4'hC;
  localparam logic [3:0] SEL_RX         = 4'hD;
  localparam logic [3:0] SEL_SUBC       = 4'hE;
  localparam logic [3:0] SEL_TBUS       = 4'hF;
  typedef enum logic [1:0] {TCAUX_FW_MIN, TCAUX_FW_MAX, TCAUX_FW_TRIM} tcaux_fw_mode_t;
endpackage : tcaux_pkg

// *** tcaux_tb.sv ***
// Self-checking testbench for the test control and auxiliary select block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tcaux_pkg::*;

  localparam logic [7:0] REV    = 8'h3C; // Arbitrary value.
  localparam logic [7:0] TB_PAT = 8'hA5;

  // Stimulus
  logic           clock, rst_n, reg_wr, reg_rd, frame_width_select, rate_106;
  logic           tx_start_phase, tx_data_phase, tx_parity_phase, tx_crc_phase;
  logic           rx_data_phase, rx_parity_phase, rx_crc_phase, subcarrier_detect;
  logic           crc_calculation_command, correlator_test_signal;
  logic [5:0]     reg_addr, first_test_dac, second_test_dac;
  logic [7:0]     reg_wdata, test_bus;
  logic [2:0]     test_bus_bit_selector, collision_level_threshold;
  logic [3:0]     minimum_signal_threshold, adc_i_value, adc_q_value;
  // Observed outputs
  logic [7:0]     reg_rdata_r;
  logic           nonlinear_receive_gain_r, self_test_enable_r, self_test_start_r;
  logic [3:0]     eff_min_threshold_r, frame_trim_cycles_r;
  logic [2:0]     eff_coll_threshold_r;
  tcaux_fw_mode_t frame_width_mode_r;
  logic           auxiliary_pin_1_out_r, auxiliary_pin_1_oe_r, auxiliary_pin_1_analog_en_r;
  logic           auxiliary_pin_2_out_r, auxiliary_pin_2_oe_r, auxiliary_pin_2_analog_en_r;
  logic [5:0]     auxiliary_pin_1_analog_code_r, auxiliary_pin_2_analog_code_r;
  int             bad_count, check_count;

  // Device under test.
  tcaux_top #(.REVISION_CODE(REV)) u_tcaux_top (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .frame_width_select(frame_width_select),
    .rate_106(rate_106), .tx_start_phase(tx_start_phase), .tx_data_phase(tx_data_phase),
    .tx_parity_phase(tx_parity_phase), .tx_crc_phase(tx_crc_phase),
    .rx_data_phase(rx_data_phase), .rx_parity_phase(rx_parity_phase),
    .rx_crc_phase(rx_crc_phase), .subcarrier_detect(subcarrier_detect),
    .crc_calculation_command(crc_calculation_command),
    .correlator_test_signal(correlator_test_signal), .test_bus(test_bus),
    .test_bus_bit_selector(test_bus_bit_selector), .first_test_dac(first_test_dac),
    .second_test_dac(second_test_dac), .minimum_signal_threshold(minimum_signal_threshold),
    .collision_level_threshold(collision_level_threshold), .adc_i_value(adc_i_value),
    .adc_q_value(adc_q_value), .nonlinear_receive_gain_r(nonlinear_receive_gain_r),
    .eff_min_threshold_r(eff_min_threshold_r), .eff_coll_threshold_r(eff_coll_threshold_r),
    .frame_width_mode_r(frame_width_mode_r), .frame_trim_cycles_r(frame_trim_cycles_r),
    .self_test_enable_r(self_test_enable_r), .self_test_start_r(self_test_start_r),
    .auxiliary_pin_1_out_r(auxiliary_pin_1_out_r), .auxiliary_pin_1_oe_r(auxiliary_pin_1_oe_r),
    .auxiliary_pin_1_analog_en_r(auxiliary_pin_1_analog_en_r), .auxiliary_pin_1_analog_code_r(auxiliary_pin_1_analog_code_r),
    .auxiliary_pin_2_out_r(auxiliary_pin_2_out_r), .auxiliary_pin_2_oe_r(auxiliary_pin_2_oe_r),
    .auxiliary_pin_2_analog_en_r(auxiliary_pin_2_analog_en_r), .auxiliary_pin_2_analog_code_r(auxiliary_pin_2_analog_code_r)
  );

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Prints the verdict once and ends the run.
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Case inequality, so an unknown never passes for a match.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Two edges cover both the register stage and the output stage.
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  // One-cycle write strobe; the register takes it at the following edge.
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data is registered at the edge that takes the strobe.
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata_r;
  endtask : reg_read

  // Values right after a reset release, then the register contents.
  task automatic t_reset_vals();
    logic [7:0] d;
    check("gain_rst", nonlinear_receive_gain_r, 1'b1);
    check("drive_rst", {auxiliary_pin_1_oe_r, auxiliary_pin_2_oe_r,
                        auxiliary_pin_1_analog_en_r, auxiliary_pin_2_analog_en_r}, 8'h00);
    reg_read(ADDR_CTRL, d);
    check("ctrl_rst", d, CTRL_RESET);
    reg_read(ADDR_AUX, d);
    check("aux_rst", d, AUX_RESET);
  endtask : t_reset_vals

  // Revision is read-only; an unmapped address reads as zero.
  task automatic t_rev();
    logic [7:0] d;
    reg_write(ADDR_REV, 8'h00);
    reg_read(ADDR_REV, d);
    check("rev", d, REV);
    reg_read(6'h3F, d);
    check("unmapped", d, RD_UNMAPPED);
  endtask : t_rev

  // Thresholds at full scale, where the square law falls just one step below linear.
  task automatic t_thresh();
    logic [7:0] d;
    @(posedge clock);
    minimum_signal_threshold  <= 4'hF;
    collision_level_threshold <= 3'h7;
    reg_write(ADDR_CTRL, 8'h00);
    settle();
    check("gain_off", nonlinear_receive_gain_r, 1'b0);
    check("min_lin", eff_min_threshold_r, 4'hF);
    check("coll_lin", eff_coll_threshold_r, 3'h7);
    reg_write(ADDR_CTRL, 8'hFF);
    settle();
    reg_read(ADDR_CTRL, d);
    check("ctrl_mask", d, 8'h5F);
    check("gain_on", nonlinear_receive_gain_r, 1'b1);
    check("min_nl", eff_min_threshold_r, 4'hE);
    check("coll_nl", eff_coll_threshold_r, 3'h6);
  endtask : t_thresh

  // All four trim and select combinations.
  task automatic t_frame();
    tcaux_fw_mode_t em;
    for (int k = 0; k < 4; k++) begin
      reg_write(ADDR_CTRL, {3'b000, k[1], 4'h0});
      frame_width_select <= k[0];
      settle();
      em = (k[0] == 1'b0) ? TCAUX_FW_MIN : (k[1] ? TCAUX_FW_TRIM : TCAUX_FW_MAX);
      check("fw_mode", 8'(frame_width_mode_r), 8'(em));
      check("fw_trim", frame_trim_cycles_r, (k == 3) ? TRIM_CYCLES : TRIM_NONE);
    end
  endtask : t_frame

  // Pulses the CRC command and checks the start pulse that follows.
  task automatic crc_pulse(input logic exp);
    @(posedge clock);
    crc_calculation_command <= 1'b1;
    @(posedge clock);
    crc_calculation_command <= 1'b0;
    #1;
    check("st_go", self_test_start_r, exp);
    @(posedge clock);
    #1;
    check("st_go_end", self_test_start_r, 1'b0);
  endtask : crc_pulse

  // Only 1001b enables; a near pattern and the normal 0000b do not.
  task automatic t_self_test();
    reg_write(ADDR_CTRL, 8'h09);
    settle();
    check("st_en", self_test_enable_r, 1'b1);
    crc_pulse(1'b1);
    reg_write(ADDR_CTRL, 8'h01);
    settle();
    check("st_near", self_test_enable_r, 1'b0);
    crc_pulse(1'b0);
    reg_write(ADDR_CTRL, 8'h00);
    settle();
    check("st_off", self_test_enable_r, 1'b0);
  endtask : t_self_test

  // Applies one set of framing phases; pin 1 and pin 2 outputs are compared.
  task automatic flag_row(input logic r, input logic [3:0] tx, input logic [2:0] rx,
                          input logic s, input logic [1:0] e);
    @(posedge clock);
    rate_106 <= r;
    {tx_start_phase, tx_data_phase, tx_parity_phase, tx_crc_phase} <= tx;
    {rx_data_phase, rx_parity_phase, rx_crc_phase} <= rx;
    subcarrier_detect <= s;
    settle();
    check("aux_flags", {auxiliary_pin_1_out_r, auxiliary_pin_2_out_r}, e);
  endtask : flag_row

  // Rate-dependent activity flags, subcarrier and test bus bit choice.
  task automatic t_flags();
    reg_write(ADDR_AUX, {SEL_TX, SEL_RX});
    flag_row(1'b1, 4'b1000, 3'b010, 1'b0, 2'b11);
    flag_row(1'b0, 4'b1010, 3'b010, 1'b0, 2'b00);
    flag_row(1'b0, 4'b0001, 3'b101, 1'b0, 2'b11);
    reg_write(ADDR_AUX, {SEL_SUBC, SEL_SUBC});
    flag_row(1'b1, 4'b0000, 3'b000, 1'b1, 2'b00);
    flag_row(1'b0, 4'b0000, 3'b000, 1'b1, 2'b11);
    reg_write(ADDR_AUX, {SEL_TBUS, SEL_TBUS});
    test_bus <= TB_PAT;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      test_bus_bit_selector <= k[2:0];
      settle();
      check("tbus", {auxiliary_pin_1_out_r, auxiliary_pin_2_out_r}, {2{TB_PAT[k]}});
    end
  endtask : t_flags

  // Writes one selector code to both pins and checks analog and digital drive.
  task automatic aux_code(input logic [3:0] c);
    logic [7:0] d;
    logic [6:0] a1, a2;
    logic [1:0] g;
    reg_write(ADDR_AUX, {c, c});
    settle();
    reg_read(ADDR_AUX, d);
    check("aux_rw", d, {c, c});
    a1 = 7'h00;
    g  = 2'b00;
    case (c)
      SEL_CORR:   a1 = {1'b1, {6{correlator_test_signal}}};
      SEL_MINLVL: a1 = {1'b1, minimum_signal_threshold, 2'b00};
      SEL_ADC_I:  a1 = {1'b1, adc_i_value, 2'b00};
      SEL_ADC_Q:  a1 = {1'b1, adc_q_value, 2'b00};
      SEL_HIGH, SEL_TX, SEL_SUBC: g = 2'b11;
      SEL_LOW, SEL_RX: g = 2'b10;
      SEL_TBUS:   g = {1'b1, TB_PAT[2]};
      default:    g = 2'b00;
    endcase
    a2 = a1;
    if (c == SEL_DAC) begin
      a1 = {1'b1, first_test_dac};
      a2 = {1'b1, second_test_dac};
    end
    check("auxiliary_pin_1_an", {auxiliary_pin_1_analog_en_r, auxiliary_pin_1_analog_code_r}, a1);
    check("auxiliary_pin_2_an", {auxiliary_pin_2_analog_en_r, auxiliary_pin_2_analog_code_r}, a2);
    if (!a1[6]) begin
      check("auxiliary_pin_1_dig", {auxiliary_pin_1_oe_r, auxiliary_pin_1_oe_r & auxiliary_pin_1_out_r},
            g);
      check("auxiliary_pin_2_dig", {auxiliary_pin_2_oe_r, auxiliary_pin_2_oe_r & auxiliary_pin_2_out_r},
            g);
    end
  endtask : aux_code

  // Every selector code on both pins, with fixed source values.
  task automatic t_codes();
    reg_write(ADDR_CTRL, 8'h00);
    @(posedge clock);
    rate_106              <= 1'b0;
    tx_data_phase         <= 1'b1;
    subcarrier_detect     <= 1'b1;
    test_bus_bit_selector <= 3'h2;
    for (int k = 0; k < 16; k++) begin
      aux_code(k[3:0]);
    end
  endtask : t_codes

  // Watchdog; the run needs only a few hundred cycles.
  initial begin
    #50us;
    bad_count++;
    finish_test();
  end

  // Main sequence; a second reset after the last test must clear the written registers.
  initial begin
    {reg_wr, reg_rd, frame_width_select, rate_106, crc_calculation_command} = 5'h00;
    {tx_start_phase, tx_data_phase, tx_parity_phase, tx_crc_phase} = 4'h0;
    {rx_data_phase, rx_parity_phase, rx_crc_phase, subcarrier_detect} = 4'h0;
    correlator_test_signal    = 1'b1;
    reg_addr                  = 6'h00;
    reg_wdata                 = 8'h00;
    test_bus                  = 8'h00;
    test_bus_bit_selector     = 3'h0;
    first_test_dac            = 6'h2B;
    second_test_dac           = 6'h14;
    minimum_signal_threshold  = 4'h9;
    collision_level_threshold = 3'h2;
    adc_i_value               = 4'h6;
    adc_q_value               = 4'hC;
    bad_count                 = 0;
    check_count               = 0;
    rst_n                     = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    t_reset_vals();
    t_rev();
    t_thresh();
    t_frame();
    t_self_test();
    t_flags();
    t_codes();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    t_reset_vals();
    finish_test();
  end
endmodule : tb

// *** tcaux_top.sv ***
// Test control register, revision register and auxiliary pin selection logic.

// One auxiliary pin source selector; both pins share the same encoding.
module tcaux_aux_mux
  import tcaux_pkg::*;
(
  // Selection
  input  wire logic [3:0] sel,
  // Sources
  input  wire logic [5:0] dac,
  input  wire logic       corr,
  input  wire logic [3:0] minlvl,
  input  wire logic [3:0] adc_i,
  input  wire logic [3:0] adc_q,
  input  wire logic       tx_act,
  input  wire logic       rx_act,
  input  wire logic       subc,
  input  wire logic       tb_bit,
  // Pin drive
  output logic            drv,
  output logic            oe,
  output logic            an_en,
  output logic [5:0]      an_code
);
  // Analog codes are scaled to the six-bit current source range.
  always_comb begin
    drv     = 1'b0;
    oe      = 1'b0;
    an_en   = 1'b0;
    an_code = 6'h00;
    unique case (sel)
      SEL_HIZ: begin
        oe = 1'b0;
      end
      SEL_DAC: begin
        an_en   = 1'b1;
        an_code = dac;
      end
      SEL_CORR: begin
        an_en   = 1'b1;
        an_code = {6{corr}};
      end
      SEL_MINLVL: begin
        an_en   = 1'b1;
        an_code = {minlvl, 2'h0};
      end
      SEL_ADC_I: begin
        an_en   = 1'b1;
        an_code = {adc_i, 2'h0};
      end
      SEL_ADC_Q: begin
        an_en   = 1'b1;
        an_code = {adc_q, 2'h0};
      end
      // Reserved codes and SEL_PROD leave the pin undriven so a stray write harms nothing.
      SEL_RSV3, SEL_RSV7, SEL_PROD, SEL_RSV9: begin
        oe = 1'b0;
      end
      SEL_HIGH: begin
        oe  = 1'b1;
        drv = 1'b1;
      end
      SEL_LOW: begin
        oe  = 1'b1;
        drv = 1'b0;
      end
      SEL_TX: begin
        oe  = 1'b1;
        drv = tx_act;
      end
      SEL_RX: begin
        oe  = 1'b1;
        drv = rx_act;
      end
      SEL_SUBC: begin
        oe  = 1'b1;
        drv = subc;
      end
      SEL_TBUS: begin
        oe  = 1'b1;
        drv = tb_bit;
      end
    endcase
  end
endmodule : tcaux_aux_mux

module tcaux_top
  import tcaux_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5A // Arbitrary value.
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Host register port
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata_r,
  // Framing status
  input  wire logic       frame_width_select,
  input  wire logic       rate_106,
  input  wire logic       tx_start_phase,
  input  wire logic       tx_data_phase,
  input  wire logic       tx_parity_phase,
  input  wire logic       tx_crc_phase,
  input  wire logic       rx_data_phase,
  input  wire logic       rx_parity_phase,
  input  wire logic       rx_crc_phase,
  input  wire logic       subcarrier_detect,
  input  wire logic       crc_calculation_command,
  // Test sources
  input  wire logic       correlator_test_signal,
  input  wire logic [7:0] test_bus,
  input  wire logic [2:0] test_bus_bit_selector,
  input  wire logic [5:0] first_test_dac,
  input  wire logic [5:0] second_test_dac,
  input  wire logic [3:0] minimum_signal_threshold,
  input  wire logic [2:0] collision_level_threshold,
  input  wire logic [3:0] adc_i_value,
  input  wire logic [3:0] adc_q_value,
  // Receiver and framing control
  output logic            nonlinear_receive_gain_r,
  output logic [3:0]      eff_min_threshold_r,
  output logic [2:0]      eff_coll_threshold_r,
  output tcaux_fw_mode_t  frame_width_mode_r,
  output logic [3:0]      frame_trim_cycles_r,
  output logic            self_test_enable_r,
  output logic            self_test_start_r,
  // Auxiliary pins
  output logic            auxiliary_pin_1_out_r,
  output logic            auxiliary_pin_1_oe_r,
  output logic            auxiliary_pin_1_analog_en_r,
  output logic [5:0]      auxiliary_pin_1_analog_code_r,
  output logic            auxiliary_pin_2_out_r,
  output logic            auxiliary_pin_2_oe_r,
  output logic            auxiliary_pin_2_analog_en_r,
  output logic [5:0]      auxiliary_pin_2_analog_code_r
);
  logic [7:0]     ctrl_r, ctrl_nxt;
  logic [7:0]     aux_sel_r, aux_sel_nxt;
  logic [7:0]     rdata_nxt;
  logic           tx_act, rx_act, subc, tb_bit;
  logic           d1, e1, a1, d2, e2, a2;
  logic [5:0]     c1, c2;
  logic [7:0]     min_sq;
  logic [5:0]     coll_sq;
  logic           nl_nxt, st_en_nxt, st_go_nxt;
  logic [3:0]     min_nxt, trim_nxt;
  logic [2:0]     coll_nxt;
  tcaux_fw_mode_t fw_nxt;

  // Register writes; the revision address has no storage so writes fall away.
  always_comb begin
    ctrl_nxt    = ctrl_r;
    aux_sel_nxt = aux_sel_r;
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_nxt = (reg_wdata & CTRL_WMASK) | (CTRL_RESET & ~CTRL_WMASK);
    end
    if (reg_wr && reg_addr == ADDR_AUX) begin
      aux_sel_nxt = reg_wdata;
    end
  end

  // Register reads return data the cycle after the strobe and then hold.
  always_comb begin
    rdata_nxt = reg_rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_REV:  rdata_nxt = REVISION_CODE;
        ADDR_AUX:  rdata_nxt = aux_sel_r;
        default:   rdata_nxt = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r      <= CTRL_RESET;
      aux_sel_r   <= AUX_RESET;
      reg_rdata_r <= RD_UNMAPPED;
    end else begin
      ctrl_r      <= ctrl_nxt;
      aux_sel_r   <= aux_sel_nxt;
      reg_rdata_r <= rdata_nxt;
    end
  end

  // Receiver shaping, frame width and self-test decode. A square law stands in
  // for the nonlinear response; it keeps the threshold ordering monotonic.
  always_comb begin
    min_sq    = 8'(minimum_signal_threshold) * 8'(minimum_signal_threshold);
    coll_sq   = 6'(collision_level_threshold) * 6'(collision_level_threshold);
    nl_nxt    = ctrl_r[BIT_NL];
    min_nxt   = nl_nxt ? min_sq[7:4] : minimum_signal_threshold;
    coll_nxt  = nl_nxt ? coll_sq[5:3] : collision_level_threshold;
    fw_nxt    = TCAUX_FW_MIN;
    trim_nxt  = TRIM_NONE;
    if (frame_width_select && !ctrl_r[BIT_TRIM]) begin
      fw_nxt = TCAUX_FW_MAX;
    end else if (frame_width_select && ctrl_r[BIT_TRIM]) begin
      fw_nxt   = TCAUX_FW_TRIM;
      trim_nxt = TRIM_CYCLES;
    end
    st_en_nxt = ctrl_r[ST_HI:ST_LO] == SELF_TEST_ON;
    st_go_nxt = st_en_nxt && crc_calculation_command;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nonlinear_receive_gain_r <= 1'b1;
      eff_min_threshold_r      <= 4'h0;
      eff_coll_threshold_r     <= 3'h0;
      frame_width_mode_r       <= TCAUX_FW_MIN;
      frame_trim_cycles_r      <= TRIM_NONE;
      self_test_enable_r       <= 1'b0;
      self_test_start_r        <= 1'b0;
    end else begin
      nonlinear_receive_gain_r <= nl_nxt;
      eff_min_threshold_r      <= min_nxt;
      eff_coll_threshold_r     <= coll_nxt;
      frame_width_mode_r       <= fw_nxt;
      frame_trim_cycles_r      <= trim_nxt;
      self_test_enable_r       <= st_en_nxt;
      self_test_start_r        <= st_go_nxt;
    end
  end

  // Activity flags: at 106 kBd the framing bits count, above it they do not.
  assign tx_act = rate_106 ? (tx_start_phase | tx_data_phase | tx_parity_phase | tx_crc_phase)
                           : (tx_data_phase | tx_crc_phase);
  assign rx_act = rate_106 ? (rx_data_phase | rx_parity_phase | rx_crc_phase)
                           : (rx_data_phase | rx_crc_phase);
  assign subc   = !rate_106 && subcarrier_detect;
  assign tb_bit = test_bus[test_bus_bit_selector];

  tcaux_aux_mux u_auxiliary_pin_1 (
    .sel     (aux_sel_r[AUXILIARY_PIN_1_HI:AUXILIARY_PIN_1_LO]),
    .dac     (first_test_dac),
    .corr    (correlator_test_signal),
    .minlvl  (minimum_signal_threshold),
    .adc_i   (adc_i_value),
    .adc_q   (adc_q_value),
    .tx_act  (tx_act),
    .rx_act  (rx_act),
    .subc    (subc),
    .tb_bit  (tb_bit),
    .drv     (d1),
    .oe      (e1),
    .an_en   (a1),
    .an_code (c1)
  );

  tcaux_aux_mux u_auxiliary_pin_2 (
    .sel     (aux_sel_r[AUXILIARY_PIN_2_HI:AUXILIARY_PIN_2_LO]),
    .dac     (second_test_dac),
    .corr    (correlator_test_signal),
    .minlvl  (minimum_signal_threshold),
    .adc_i   (adc_i_value),
    .adc_q   (adc_q_value),
    .tx_act  (tx_act),
    .rx_act  (rx_act),
    .subc    (subc),
    .tb_bit  (tb_bit),
    .drv     (d2),
    .oe      (e2),
    .an_en   (a2),
    .an_code (c2)
  );

  // Pin drive is registered so the pads never see selector decode glitches.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      auxiliary_pin_1_out_r <= 1'b0;
      auxiliary_pin_1_oe_r  <= 1'b0;
      auxiliary_pin_1_analog_en_r      <= 1'b0;
      auxiliary_pin_1_analog_code_r    <= 6'h00;
      auxiliary_pin_2_out_r <= 1'b0;
      auxiliary_pin_2_oe_r  <= 1'b0;
      auxiliary_pin_2_analog_en_r      <= 1'b0;
      auxiliary_pin_2_analog_code_r    <= 6'h00;
    end else begin
      auxiliary_pin_1_out_r <= d1;
      auxiliary_pin_1_oe_r  <= e1;
      auxiliary_pin_1_analog_en_r      <= a1;
      auxiliary_pin_1_analog_code_r    <= c1;
      auxiliary_pin_2_out_r <= d2;
      auxiliary_pin_2_oe_r  <= e2;
      auxiliary_pin_2_analog_en_r      <= a2;
      auxiliary_pin_2_analog_code_r    <= c2;
    end
  end

  // Checks on the registered behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_reset_vals;
    $rose(rst_n) |-> ctrl_r == CTRL_RESET && aux_sel_r == AUX_RESET && nonlinear_receive_gain_r;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong.");

  property p_ctrl_rsv;
    reg_wr && reg_addr == ADDR_CTRL |=> ctrl_r[7] == 1'b0 && ctrl_r[5] == 1'b0
      && ctrl_r[6] == $past(reg_wdata[6]) && ctrl_r[3:0] == $past(reg_wdata[3:0]);
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("Control write wrong.");

  // A write to the revision address must leave every stored register alone.
  property p_rev_ro;
    reg_wr && reg_addr == ADDR_REV |=> $stable(ctrl_r) && $stable(aux_sel_r);
  endproperty
  a_rev_ro: assert property (p_rev_ro) else $error("Revision not read only.");

  property p_rev_rd;
    reg_rd && reg_addr == ADDR_REV |=> reg_rdata_r == REVISION_CODE;
  endproperty
  a_rev_rd: assert property (p_rev_rd) else $error("Revision read wrong.");

  property p_nl_gain;
    reg_wr && reg_addr == ADDR_CTRL ##1 !(reg_wr && reg_addr == ADDR_CTRL)
      |=> nonlinear_receive_gain_r == $past(reg_wdata[BIT_NL], 2);
  endproperty
  a_nl_gain: assert property (p_nl_gain) else $error("Gain bit not applied.");

  property p_trim;
    frame_width_select && ctrl_r[BIT_TRIM]
      |=> frame_width_mode_r == TCAUX_FW_TRIM && frame_trim_cycles_r == 4'h8;
  endproperty
  a_trim: assert property (p_trim) else $error("Trim mode wrong.");

  property p_fw_max;
    frame_width_select && !ctrl_r[BIT_TRIM] |=> frame_width_mode_r == TCAUX_FW_MAX;
  endproperty
  a_fw_max: assert property (p_fw_max) else $error("Max width wrong.");

  property p_fw_min;
    !frame_width_select |=> frame_width_mode_r == TCAUX_FW_MIN && frame_trim_cycles_r == 4'h0;
  endproperty
  a_fw_min: assert property (p_fw_min) else $error("Min width wrong.");

  property p_selftest;
    self_test_start_r |-> self_test_enable_r && $past(crc_calculation_command)
      && $past(ctrl_r[3:0]) == 4'h9;
  endproperty
  a_selftest: assert property (p_selftest) else $error("Self-test start wrong.");

  property p_aux_hiz;
    aux_sel_r[7:4] == 4'h0 |=> !auxiliary_pin_1_oe_r && !auxiliary_pin_1_analog_en_r;
  endproperty
  a_aux_hiz: assert property (p_aux_hiz) else $error("Pin 1 not released.");

  property p_aux_high;
    aux_sel_r[3:0] == 4'hA ##1 aux_sel_r[3:0] == 4'hB
      |-> auxiliary_pin_2_oe_r && auxiliary_pin_2_out_r ##1 !auxiliary_pin_2_out_r;
  endproperty
  a_aux_high: assert property (p_aux_high) else $error("Pin 2 level wrong.");

  property p_tx_106;
    aux_sel_r[7:4] == 4'hC && rate_106 && tx_start_phase |=> auxiliary_pin_1_out_r;
  endproperty
  a_tx_106: assert property (p_tx_106) else $error("Transmit flag wrong.");

  property p_tbus;
    aux_sel_r[3:0] == 4'hF |=> auxiliary_pin_2_oe_r
      && auxiliary_pin_2_out_r == $past(test_bus[test_bus_bit_selector]);
  endproperty
  a_tbus: assert property (p_tbus) else $error("Test bus bit wrong.");
endmodule : tcaux_top
